// ---- verilog/cir_device_end.sv ----
`timescale 1ns/1ps
// How it works
// - Top bit gates all interrupts, mode off
// - Mode on: top bit enables high priority
// - Mode off: bit six gates peripheral interrupts
// - Mode on: bit six enables low priority
// - Bit five enables timer0 overflow
// - Bit four enables external pin zero
// - Bit three enables port change
// - Timer0 overflow sets bit two flag
// - External pin event sets bit one flag
// - Upper port pin change sets bit zero
// - Mismatch keeps setting until port read
// - Flags set regardless of any enable
module cir_device_end
  import cir_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  cir_if.device           bus,
  input  wire logic       priority_mode_enable,
  input  wire logic       timer0_overflow,
  input  wire logic       ext_pin0,
  input  wire logic       ext_edge_rising,
  input  wire logic [3:0] port_b_upper_pins,
  input  wire logic       periph_irq_pending,
  input  wire logic       periph_irq_high_prio,
  output logic      [7:0] interrupt_control
);
  // Synchroniser and edge state for the external pin
  logic [1:0]                     ext_sync_q;
  logic [1:0]                     ext_sync_d;
  logic                           ext_prev_q;
  logic                           ext_prev_d;
  logic                           ext_rise;
  logic                           ext_fall;
  logic                           ext_event;

  // Port lanes and the mismatch against the last port read
  logic [3:0]                     pb_s1_q;
  logic [3:0]                     pb_s2_q;
  logic [3:0]                     pb_latch_q;
  logic [3:0]                     pb_differs;
  logic                           mismatch;

  // Register fields, enables high and flags low
  logic [BIT_GLOBAL:BIT_PC_EN]    en_q;
  logic [BIT_GLOBAL:BIT_PC_EN]    en_d;
  logic [BIT_T0_FLAG:BIT_PC_FLAG] flag_q;
  logic [BIT_T0_FLAG:BIT_PC_FLAG] src_event;
  logic [BIT_T0_FLAG:BIT_PC_FLAG] src_pend;
  logic [7:0]                     ctl_word;

  // Request formation
  logic                           core_pend;
  logic                           global_on;
  logic                           periph_on;
  logic                           periph_hi;
  logic                           periph_lo;
  logic                           flat_high;
  logic                           prio_high;
  logic                           prio_low;
  logic                           req_high;
  logic                           req_low;

  // Pins pass two flops before use
  always_comb begin
    ext_sync_d = {ext_sync_q[0], ext_pin0};
    ext_prev_d = ext_sync_q[1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= ext_sync_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  // Edge chosen by the polarity input
  assign ext_rise  = ext_sync_q[1] & ~ext_prev_q;
  assign ext_fall  = ~ext_sync_q[1] & ext_prev_q;
  assign ext_event = ext_edge_rising ? ext_rise : ext_fall;

  // One lane per upper port pin
  for (genvar p = 0; p < 4; p++) begin : g_port
    logic s1_d;
    logic s2_d;
    logic latch_d;

    // Pins pass two flops before use
    always_comb begin
      s1_d = port_b_upper_pins[p];
      s2_d = pb_s1_q[p];
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pb_s1_q[p] <= PORT_UP_RESET[p];
        pb_s2_q[p] <= PORT_UP_RESET[p];
      end else begin
        pb_s1_q[p] <= s1_d;
        pb_s2_q[p] <= s2_d;
      end
    end

    // Port read takes a new reference value
    always_comb begin
      latch_d = pb_latch_q[p];
      if (bus.port_read) begin
        latch_d = pb_s2_q[p];
      end
    end

    // Latch resets low, so low pins count as settled
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pb_latch_q[p] <= PORT_UP_RESET[p];
      end else begin
        pb_latch_q[p] <= latch_d;
      end
    end

    // Pin differs from the last read
    assign pb_differs[p] = pb_s2_q[p] ^ pb_latch_q[p];
  end

  // Read ends the mismatch; until then it sets
  assign mismatch = (|pb_differs) & ~bus.port_read;

  // Overflow pulse from the timer0 count
  assign src_event[BIT_T0_FLAG]  = timer0_overflow;
  assign src_event[BIT_EXT_FLAG] = ext_event;
  assign src_event[BIT_PC_FLAG]  = mismatch;

  always_comb begin
    en_d = en_q;
    if (bus.wr_en) begin
      en_d = bus.wr_data[BIT_GLOBAL:BIT_PC_EN];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= CIR_RESET[BIT_GLOBAL:BIT_PC_EN];
    end else begin
      en_q <= en_d;
    end
  end

  // Set ignores enables and beats a write
  for (genvar s = BIT_PC_FLAG; s <= BIT_T0_FLAG; s++) begin : g_flag
    logic flag_d;

    always_comb begin
      flag_d = flag_q[s];
      if (bus.wr_en) begin
        flag_d = bus.wr_data[s];
      end
      // Event last, so a set is never lost to a clear
      if (src_event[s]) begin
        flag_d = 1'b1;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flag_q[s] <= CIR_RESET[s];
      end else begin
        flag_q[s] <= flag_d;
      end
    end

    // Flag counts only with its own enable
    assign src_pend[s] = flag_q[s] & en_q[s + BIT_PC_EN - BIT_PC_FLAG];
  end

  // Reads see the flops directly, no extra delay
  assign ctl_word  = {en_q, flag_q};
  assign core_pend = |src_pend;
  assign global_on = en_q[BIT_GLOBAL];
  assign periph_on = en_q[BIT_PERIPH];
  assign periph_hi = periph_irq_pending & periph_irq_high_prio;
  assign periph_lo = periph_irq_pending & ~periph_irq_high_prio;

  // Mode off: one level, peripherals gated
  assign flat_high = global_on & (core_pend | (periph_on & periph_irq_pending));

  // Mode on: core sources count as high priority
  assign prio_high = global_on & (core_pend | periph_hi);

  // Low priority also needs the top bit
  assign prio_low  = global_on & periph_on & periph_lo;

  // Mode picks which pair reaches the core
  always_comb begin
    req_high = flat_high;
    req_low  = 1'b0;
    if (priority_mode_enable) begin
      req_high = prio_high;
      req_low  = prio_low;
    end
  end

  assign bus.irq_high      = req_high;
  assign bus.irq_low       = req_low;
  assign bus.rd_data       = ctl_word;
  assign interrupt_control = ctl_word;
endmodule

// ---- shared/cir_pkg.sv ----
package cir_pkg;
  localparam int          CIR_W          = 8;
  localparam int          BIT_GLOBAL     = 7;
  localparam int          BIT_PERIPH     = 6;
  localparam int          BIT_T0_EN      = 5;
  localparam int          BIT_EXT_EN     = 4;
  localparam int          BIT_PC_EN      = 3;
  localparam int          BIT_T0_FLAG    = 2;
  localparam int          BIT_EXT_FLAG   = 1;
  localparam int          BIT_PC_FLAG    = 0;
  localparam logic [7:0]  CIR_RESET      = 8'h00;
  localparam logic [3:0]  PORT_UP_RESET  = 4'h0;
  typedef enum logic [1:0] {
    CIR_CMD_IDLE,
    CIR_CMD_WRITE,
    CIR_CMD_READ_PORT
  } cir_cmd_e;
endpackage

// ---- shared/cir_if.sv ----
`timescale 1ns/1ps
interface cir_if;
  import cir_pkg::*;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       port_read;
  logic       irq_high;
  logic       irq_low;
  modport device (
    input  wr_en,
    input  wr_data,
    input  port_read,
    output rd_data,
    output irq_high,
    output irq_low
  );
  modport core (
    output wr_en,
    output wr_data,
    output port_read,
    input  rd_data,
    input  irq_high,
    input  irq_low
  );
endinterface

// ---- verilog/cir_core_end.sv ----
`timescale 1ns/1ps
module cir_core_end
  import cir_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  cir_if.core             bus,
  input  wire logic       sw_wr,
  input  wire logic [7:0] sw_wr_data,
  input  wire logic       sw_port_read,
  output logic      [7:0] sw_rd_data,
  output logic            sw_irq_high,
  output logic            sw_irq_low
);
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic       hi_q;
  logic       hi_d;
  logic       lo_q;
  logic       lo_d;

  // Software clears flags by writing zeros
  assign bus.wr_en     = sw_wr;
  assign bus.wr_data   = sw_wr_data;
  // Reading the port ends a mismatch
  assign bus.port_read = sw_port_read;

  always_comb begin
    rd_d = bus.rd_data;
    hi_d = bus.irq_high;
    lo_d = bus.irq_low;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= CIR_RESET;
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  assign sw_rd_data  = rd_q;
  assign sw_irq_high = hi_q;
  assign sw_irq_low  = lo_q;
endmodule

// ---- tb/cir_props.sv ----
`timescale 1ns/1ps
module cir_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic       irq_high,
  input wire logic       irq_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence t0_on_s;
    rd_data[7] && rd_data[5] && rd_data[2];
  endsequence
  wr_take_a: assert property (wr_en |=> rd_data[7:3] == $past(wr_data[7:3]))
    else $error("write lost");
  gbl_off_a: assert property (!rd_data[7] |-> !irq_high && !irq_low)
    else $error("irq while off");
  low_off_a: assert property (!rd_data[6] |-> !irq_low)
    else $error("low irq while off");
  t0_req_a: assert property (t0_on_s |-> irq_high)
    else $error("no t0 irq");
  ext_req_a: assert property (rd_data[7] && rd_data[4] && rd_data[1] |-> irq_high)
    else $error("no ext irq");
  pc_req_a: assert property (rd_data[7] && rd_data[3] && rd_data[0] |-> irq_high)
    else $error("no pc irq");
  t0_hold_a: assert property (rd_data[2] && !wr_en |=> rd_data[2])
    else $error("t0 flag lost");
  ext_hold_a: assert property (rd_data[1] && !wr_en |=> rd_data[1])
    else $error("ext flag lost");
  pc_hold_a: assert property (rd_data[0] && !wr_en |=> rd_data[0])
    else $error("pc flag lost");
endmodule

// ---- tb/core_interrupt_control_reg_tb.sv ----
`timescale 1ns/1ps
module core_interrupt_control_reg_tb;
  logic       clk = 0, rst_n = 0, sw_wr = 0, prd = 0, mode = 0, t0 = 0, pin = 0, pend = 0, rise = 1, hp = 0;
  logic [7:0] sw_d = 8'h00;
  logic [7:0] sw_rd, ctl_out;
  logic       sw_hi, sw_lo;
  logic [3:0] pb = 4'h0;
  int         n_errors = 0, n_tests = 0;
  logic [8:0] rows [7] = '{9'h1A4, 9'h024, 9'h084, 9'h192, 9'h082, 9'h189, 9'h081};
  cir_if cir_if_i ();
  cir_core_end cir_core_end_i (.clk(clk), .rst_n(rst_n), .bus(cir_if_i.core), .sw_wr(sw_wr), .sw_wr_data(sw_d),
    .sw_port_read(prd), .sw_rd_data(sw_rd), .sw_irq_high(sw_hi), .sw_irq_low(sw_lo));
  cir_device_end cir_device_end_i (.clk(clk), .rst_n(rst_n), .bus(cir_if_i.device), .priority_mode_enable(mode),
    .timer0_overflow(t0), .ext_pin0(pin), .ext_edge_rising(rise), .port_b_upper_pins(pb),
    .periph_irq_pending(pend), .periph_irq_high_prio(hp), .interrupt_control(ctl_out));
  cir_props cir_props_i (.clk(clk), .rst_n(rst_n), .wr_en(cir_if_i.wr_en), .wr_data(cir_if_i.wr_data),
    .rd_data(cir_if_i.rd_data), .irq_high(cir_if_i.irq_high), .irq_low(cir_if_i.irq_low));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Extra tick keeps strobe edges apart
  task automatic wr(input logic [7:0] d);
    sw_wr = 1;
    sw_d = d;
    tick();
    sw_wr = 0;
    tick();
  endtask
  task automatic tally_and_finish();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    tick(5);
    rst_n = 1;
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h000);
    foreach (rows[i]) begin
      wr(rows[i][7:0]);
      chk({cir_if_i.irq_high, cir_if_i.rd_data}, rows[i]);
      chk({sw_hi, sw_rd}, rows[i]);
      chk({1'b0, ctl_out}, {1'b0, rows[i][7:0]});
    end
    pend = 1;
    wr(8'hC0);
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h1C0);
    wr(8'h80);
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h080);
    mode = 1;
    wr(8'hC0);
    chk({cir_if_i.irq_low, cir_if_i.rd_data}, 9'h1C0);
    chk({sw_lo, sw_rd}, 9'h1C0);
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h0C0);
    wr(8'h80);
    chk({cir_if_i.irq_low, cir_if_i.rd_data}, 9'h080);
    hp = 1;
    tick();
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h180);
    chk({cir_if_i.irq_low, cir_if_i.rd_data}, 9'h080);
    wr(8'h40);
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h040);
    hp = 0;
    tick();
    chk({cir_if_i.irq_low, cir_if_i.rd_data}, 9'h040);
    mode = 0;
    pend = 0;
    wr(8'h00);
    t0 = 1;
    tick();
    t0 = 0;
    tick(3);
    chk({1'b0, cir_if_i.rd_data}, 9'h004);
    pin = 1;
    tick(5);
    chk({1'b0, cir_if_i.rd_data}, 9'h006);
    pb = 4'h8;
    tick(4);
    chk({1'b0, cir_if_i.rd_data}, 9'h007);
    // Clear refused until the port is read
    wr(8'h00);
    chk({1'b0, cir_if_i.rd_data}, 9'h001);
    prd = 1;
    tick();
    prd = 0;
    tick(3);
    wr(8'h00);
    chk({1'b0, cir_if_i.rd_data}, 9'h000);
    // Falling edge selected on the external pin
    rise = 0;
    pin = 0;
    tick(5);
    chk({1'b0, cir_if_i.rd_data}, 9'h002);
    wr(8'h00);
    chk({1'b0, cir_if_i.rd_data}, 9'h000);
    // Reset mid-run with the request line up
    wr(8'hA4);
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h1A4);
    pb = 4'h0;
    rst_n = 0;
    tick();
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h000);
    chk({sw_hi, sw_rd}, 9'h000);
    rst_n = 1;
    tick(4);
    chk({cir_if_i.irq_high, cir_if_i.rd_data}, 9'h000);
    chk({sw_lo, ctl_out}, 9'h000);
    tally_and_finish();
  end
endmodule
